// ==== src/dcc_decoder.sv ====
`timescale 1ns/100ps

module dcc_decoder
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mem_clk,
  input wire logic reset_n,
  input wire dcc_pkg::dcc_pins_t pins,
  output dcc_pkg::dcc_cmd_t cmd_q,
  output logic cmd_stb_q,
  output logic [2:0] cmd_bank_q,
  output logic [15:0] cmd_addr_q,
  output dcc_pkg::dcc_pstate_t pstate_q,
  output logic idle_q,
  output logic [7:0] bank_open_q,
  output logic burst_active_q,
  output logic burst_write_q,
  output logic burst_chop_q,
  output logic burst_autoclose_q,
  output logic mr_write_stb_q,
  output logic [1:0] mr_sel_q,
  output logic [15:0] mr_data_q,
  output logic [15:0] mr0_q
);
  import dcc_pkg::*;

  // ==========================================================
  // Synchronisers
  dcc_pins_t pins_s1_q;
  dcc_pins_t pins_s2_q;
  logic [1:0] clk_s_q;
  logic clk_d_q;
  logic [1:0] rstn_s_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pins_s1_q <= DCC_PINS_RST;
      pins_s2_q <= DCC_PINS_RST;
      clk_s_q <= 2'h0;
      clk_d_q <= 1'b0;
      rstn_s_q <= 2'h0;
    end
    else
    begin
      pins_s1_q <= pins;
      pins_s2_q <= pins_s1_q;
      clk_s_q <= {clk_s_q[0], mem_clk};
      clk_d_q <= clk_s_q[1];
      rstn_s_q <= {rstn_s_q[0], reset_n};
    end
  end

  // Pins share the clock's latency, so s2 holds their value at the edge
  logic edge_w;
  logic clr_w;
  assign edge_w = clk_s_q[1] & ~clk_d_q;
  // Pin reset is sampled, so it acts within a few ref_clk cycles, clock or not
  assign clr_w = rst | ~rstn_s_q[1];

  // ==========================================================
  // Clock-enable qualification
  logic cke_f_q;
  logic [2:0] cke_cnt_q;
  logic cke_now_w;

  function automatic logic cke_take(input logic raw, input logic held, input logic [2:0] cnt);
    cke_take = (raw != held) && (cnt == DCC_CKE_MIN_EDGES - 3'h1);
  endfunction

  assign cke_now_w = cke_take(pins_s2_q.cke, cke_f_q, cke_cnt_q) ? pins_s2_q.cke : cke_f_q;

  always_ff @(posedge ref_clk)
  begin
    if (clr_w)
    begin
      cke_f_q <= 1'b0;
      cke_cnt_q <= 3'h0;
    end
    else if (pstate_q == DCC_SELF_REFRESH && pins_s2_q.cke)
    begin
      cke_f_q <= 1'b1;
      cke_cnt_q <= 3'h0;
    end
    else if (edge_w)
    begin
      if (cke_take(pins_s2_q.cke, cke_f_q, cke_cnt_q))
      begin
        cke_f_q <= pins_s2_q.cke;
        cke_cnt_q <= 3'h0;
      end
      else if (pins_s2_q.cke != cke_f_q)
        cke_cnt_q <= cke_cnt_q + 3'h1;
      else
        cke_cnt_q <= 3'h0;
    end
  end

  // ==========================================================
  // Command decode; termination control has no input here at all
  logic [2:0] pat_w;
  dcc_cmd_t raw_cmd_w;
  assign pat_w = {pins_s2_q.ras_n, pins_s2_q.cas_n, pins_s2_q.we_n};

  always_comb
  begin
    raw_cmd_w = DCC_DESELECT;
    if (!pins_s2_q.cs_n)
    begin
      case (pat_w)
        DCC_PAT_MRS: raw_cmd_w = DCC_MODE_REGISTER_WRITE;
        DCC_PAT_REF: raw_cmd_w = DCC_REFRESH;
        DCC_PAT_PRE: raw_cmd_w = pins_s2_q.addr[DCC_A_AUTO] ? DCC_ALL_BANK_CLOSE : DCC_PRECHARGE;
        DCC_PAT_ACT: raw_cmd_w = DCC_ROW_OPEN;
        DCC_PAT_WR: raw_cmd_w = DCC_WRITE;
        DCC_PAT_RD: raw_cmd_w = DCC_READ;
        DCC_PAT_ZQ: raw_cmd_w = pins_s2_q.addr[DCC_A_AUTO] ? DCC_LONG_IMPEDANCE_CAL
                                                            : DCC_SHORT_IMPEDANCE_CAL;
        DCC_PAT_NOP: raw_cmd_w = DCC_IDLE_CYCLE;
        default: raw_cmd_w = DCC_DESELECT;
      endcase
    end
  end

  logic quiet_w;
  logic is_idle_w;
  assign quiet_w = (raw_cmd_w == DCC_DESELECT) || (raw_cmd_w == DCC_IDLE_CYCLE);
  assign is_idle_w = (bank_open_q == 8'h00) && !burst_active_q && cke_f_q;

  // ==========================================================
  // Action selection from CKE(n-1), CKE(n) and state
  dcc_cmd_t act_w;
  dcc_pstate_t next_ps_w;

  always_comb
  begin
    act_w = DCC_DESELECT;
    next_ps_w = pstate_q;
    case (pstate_q)
      DCC_AWAKE:
      begin
        if (cke_f_q && !cke_now_w)
        begin
          if (raw_cmd_w == DCC_REFRESH && is_idle_w)
          begin
            act_w = DCC_SELF_REFRESH_ENTRY;
            next_ps_w = DCC_SELF_REFRESH;
          end
          else if (quiet_w)
          begin
            act_w = DCC_POWERDOWN_ENTRY;
            next_ps_w = (bank_open_q != 8'h00) ? DCC_ACTIVE_PD : DCC_PRECHARGE_PD;
          end
        end
        else if (cke_f_q && cke_now_w)
          act_w = raw_cmd_w;
      end
      DCC_PRECHARGE_PD, DCC_ACTIVE_PD:
      begin
        // No refresh is ever started from here
        if (!cke_f_q && cke_now_w && quiet_w)
        begin
          act_w = DCC_POWERDOWN_EXIT;
          next_ps_w = DCC_AWAKE;
        end
      end
      DCC_SELF_REFRESH: next_ps_w = DCC_SELF_REFRESH;
      default: next_ps_w = DCC_AWAKE;
    endcase
  end

  // ==========================================================
  // Power state and command output
  logic srx_w;
  assign srx_w = (pstate_q == DCC_SELF_REFRESH) && pins_s2_q.cke;

  always_ff @(posedge ref_clk)
  begin
    if (clr_w)
    begin
      pstate_q <= DCC_AWAKE;
      cmd_q <= DCC_DESELECT;
      cmd_stb_q <= 1'b0;
      cmd_bank_q <= 3'h0;
      cmd_addr_q <= 16'h0000;
    end
    else if (srx_w)
    begin
      pstate_q <= DCC_AWAKE;
      cmd_q <= DCC_SELF_REFRESH_EXIT;
      cmd_stb_q <= 1'b1;
    end
    else if (edge_w)
    begin
      pstate_q <= next_ps_w;
      cmd_q <= act_w;
      // Deselect and idle cycles produce no strobe
      cmd_stb_q <= (act_w != DCC_DESELECT) && (act_w != DCC_IDLE_CYCLE);
      cmd_bank_q <= pins_s2_q.ba;
      cmd_addr_q <= pins_s2_q.addr;
    end
    else
      cmd_stb_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr_w)
      idle_q <= 1'b0;
    else
      idle_q <= (pstate_q == DCC_AWAKE) && is_idle_w;
  end

  // ==========================================================
  // Mode registers
  logic mrs_w;
  assign mrs_w = edge_w && !srx_w && (act_w == DCC_MODE_REGISTER_WRITE)
                 && (pins_s2_q.ba[2] == 1'b0);

  always_ff @(posedge ref_clk)
  begin
    if (clr_w)
    begin
      mr_write_stb_q <= 1'b0;
      mr_sel_q <= 2'h0;
      mr_data_q <= 16'h0000;
      mr0_q <= DCC_MR0_RST;
    end
    else
    begin
      mr_write_stb_q <= mrs_w;
      if (mrs_w)
      begin
        mr_sel_q <= pins_s2_q.ba[1:0];
        mr_data_q <= pins_s2_q.addr;
        if (pins_s2_q.ba[1:0] == 2'h0)
          mr0_q <= pins_s2_q.addr;
      end
    end
  end

  // ==========================================================
  // Bank tracking and bursts
  logic [1:0] bl_w;
  logic chop_w;
  logic rw_w;
  logic [2:0] burst_cnt_q;
  logic [2:0] burst_bank_q;
  logic burst_end_w;

  assign bl_w = mr0_q[DCC_MR0_BL_LSB +: 2];
  always_comb
  begin
    case (bl_w)
      DCC_BL_PER_CMD: chop_w = ~pins_s2_q.addr[DCC_A_CHOP];
      DCC_BL_FIXED4: chop_w = 1'b1;
      DCC_BL_FIXED8: chop_w = 1'b0;
      default: chop_w = 1'b0;
    endcase
  end

  assign rw_w = edge_w && !srx_w && ((act_w == DCC_READ) || (act_w == DCC_WRITE));
  assign burst_end_w = edge_w && burst_active_q && (burst_cnt_q == 3'h1);

  always_ff @(posedge ref_clk)
  begin
    if (clr_w)
    begin
      burst_active_q <= 1'b0;
      burst_write_q <= 1'b0;
      burst_chop_q <= 1'b0;
      burst_autoclose_q <= 1'b0;
      burst_cnt_q <= 3'h0;
      burst_bank_q <= 3'h0;
    end
    else if (burst_active_q)
    begin
      // A running burst ignores every command until it has run out
      if (edge_w)
        burst_cnt_q <= burst_cnt_q - 3'h1;
      if (burst_end_w)
        burst_active_q <= 1'b0;
    end
    else if (rw_w)
    begin
      burst_active_q <= 1'b1;
      burst_write_q <= (act_w == DCC_WRITE);
      burst_chop_q <= chop_w;
      burst_autoclose_q <= pins_s2_q.addr[DCC_A_AUTO];
      burst_cnt_q <= chop_w ? DCC_BURST_CHOP : DCC_BURST_FULL;
      burst_bank_q <= pins_s2_q.ba;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr_w)
      bank_open_q <= 8'h00;
    else
    begin
      if (edge_w && !srx_w)
      begin
        case (act_w)
          DCC_ROW_OPEN: bank_open_q[pins_s2_q.ba] <= 1'b1;
          DCC_PRECHARGE: bank_open_q[pins_s2_q.ba] <= 1'b0;
          DCC_ALL_BANK_CLOSE: bank_open_q <= 8'h00;
          default: bank_open_q <= bank_open_q;
        endcase
      end
      if (burst_end_w && burst_autoclose_q)
        bank_open_q[burst_bank_q] <= 1'b0;
    end
  end

endmodule

// ==== src/dcc_pkg.sv ====
package dcc_pkg;

  // ==========================================================
  // Pin bundle sampled from the command/address bus
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [2:0] ba;
    logic [15:0] addr;
  } dcc_pins_t;

  localparam int DCC_PINS_W = $bits(dcc_pins_t);
  localparam dcc_pins_t DCC_PINS_RST = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
    we_n: 1'b1, cke: 1'b0, ba: 3'h0, addr: 16'h0000};

  // ==========================================================
  // Decoded commands
  typedef enum logic [3:0] {
    DCC_DESELECT = 4'b0000,
    DCC_IDLE_CYCLE = 4'b0001,
    DCC_MODE_REGISTER_WRITE = 4'b0010,
    DCC_REFRESH = 4'b0011,
    DCC_SELF_REFRESH_ENTRY = 4'b0100,
    DCC_SELF_REFRESH_EXIT = 4'b0101,
    DCC_PRECHARGE = 4'b0110,
    DCC_ALL_BANK_CLOSE = 4'b0111,
    DCC_ROW_OPEN = 4'b1000,
    DCC_WRITE = 4'b1001,
    DCC_READ = 4'b1010,
    DCC_LONG_IMPEDANCE_CAL = 4'b1011,
    DCC_SHORT_IMPEDANCE_CAL = 4'b1100,
    DCC_POWERDOWN_ENTRY = 4'b1101,
    DCC_POWERDOWN_EXIT = 4'b1110
  } dcc_cmd_t;

  // Clock-enable power states
  typedef enum logic [1:0] {
    DCC_AWAKE = 2'b00,
    DCC_PRECHARGE_PD = 2'b01,
    DCC_ACTIVE_PD = 2'b10,
    DCC_SELF_REFRESH = 2'b11
  } dcc_pstate_t;

  // ==========================================================
  // Strobe patterns {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] DCC_PAT_MRS = 3'h0;
  localparam logic [2:0] DCC_PAT_REF = 3'h1;
  localparam logic [2:0] DCC_PAT_PRE = 3'h2;
  localparam logic [2:0] DCC_PAT_ACT = 3'h3;
  localparam logic [2:0] DCC_PAT_WR = 3'h4;
  localparam logic [2:0] DCC_PAT_RD = 3'h5;
  localparam logic [2:0] DCC_PAT_ZQ = 3'h6;
  localparam logic [2:0] DCC_PAT_NOP = 3'h7;

  // Address bit roles
  localparam int DCC_A_AUTO = 10;
  localparam int DCC_A_CHOP = 12;

  // Burst-length field of mode register zero
  localparam int DCC_MR0_BL_LSB = 0;
  localparam logic [1:0] DCC_BL_FIXED8 = 2'h0;
  localparam logic [1:0] DCC_BL_PER_CMD = 2'h1;
  localparam logic [1:0] DCC_BL_FIXED4 = 2'h2;
  localparam logic [15:0] DCC_MR0_RST = 16'h0000;

  // Burst lengths in memory-clock edges
  localparam logic [2:0] DCC_BURST_FULL = 3'h4;
  localparam logic [2:0] DCC_BURST_CHOP = 3'h2;

  // Consecutive edges a new clock-enable level must hold
  localparam logic [2:0] DCC_CKE_MIN_EDGES = 3'h3;

  localparam logic [1:0] DCC_MR_COUNT_M1 = 2'h3;

endpackage

// ==== tb/dcc_decoder_monitor.sv ====
`timescale 1ns/100ps
module dcc_decoder_monitor
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire dcc_pkg::dcc_cmd_t cmd_q,
  input wire logic cmd_stb_q,
  input wire logic [2:0] cmd_bank_q,
  input wire logic [15:0] cmd_addr_q,
  input wire dcc_pkg::dcc_pstate_t pstate_q,
  input wire logic idle_q,
  input wire logic [7:0] bank_open_q,
  input wire logic burst_active_q,
  input wire logic burst_write_q,
  input wire logic burst_chop_q,
  input wire logic mr_write_stb_q,
  input wire logic [1:0] mr_sel_q
);
  import dcc_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Command reporting
  a_stb_real_cmd: assert property (cmd_stb_q |-> cmd_q != DCC_DESELECT &&
    cmd_q != DCC_IDLE_CYCLE) else $error("strobe on idle or deselect");
  a_stb_one_cycle: assert property (cmd_stb_q |=> !cmd_stb_q) else $error("strobe too long");
  a_open_bank_set: assert property (cmd_stb_q && cmd_q == DCC_ROW_OPEN |->
    bank_open_q[cmd_bank_q]) else $error("opened bank not marked");
  a_mr_select: assert property (mr_write_stb_q |-> mr_sel_q == cmd_bank_q[1:0] &&
    cmd_q == DCC_MODE_REGISTER_WRITE) else $error("mode register select wrong");
  a_cal_form: assert property (cmd_stb_q && (cmd_q == DCC_LONG_IMPEDANCE_CAL ||
    cmd_q == DCC_SHORT_IMPEDANCE_CAL) |-> cmd_addr_q[10] == (cmd_q == DCC_LONG_IMPEDANCE_CAL))
    else $error("calibration form wrong");
  // ==========================================================
  // Power states and bursts
  a_idle_meaning: assert property (idle_q |-> $past(bank_open_q) == 8'h00 &&
    !$past(burst_active_q)) else $error("idle with open bank or burst");
  a_ppd_closed: assert property ($changed(pstate_q) && pstate_q == DCC_PRECHARGE_PD |->
    bank_open_q == 8'h00) else $error("precharge power-down with open bank");
  a_apd_open: assert property (pstate_q == DCC_ACTIVE_PD |-> bank_open_q != 8'h00)
    else $error("active power-down without open bank");
  a_sr_from_idle: assert property ($changed(pstate_q) && pstate_q == DCC_SELF_REFRESH |->
    $past(idle_q)) else $error("self refresh entered when not idle");
  a_pd_frozen: assert property (pstate_q == DCC_PRECHARGE_PD || pstate_q == DCC_ACTIVE_PD
    |=> $stable(bank_open_q)) else $error("banks changed in power-down");
  a_burst_kept: assert property (burst_active_q && $past(burst_active_q) && cmd_stb_q &&
    (cmd_q == DCC_READ || cmd_q == DCC_WRITE) |-> $stable(burst_write_q) &&
    $stable(burst_chop_q)) else $error("running burst altered");
endmodule
bind dcc_decoder dcc_decoder_monitor mon (.*);

// ==== tb/dcc_ctrl_model.sv ====
`timescale 1ns/100ps
module dcc_ctrl_model
(
  input wire logic ref_clk,
  output logic mem_clk,
  output dcc_pkg::dcc_pins_t pins
);
  import dcc_pkg::*;
  initial
  begin
    mem_clk = 1'b0;
    pins = DCC_PINS_RST;
  end
  // ==========================================================
  // One memory-clock period; the clock rests low between calls
  task cyc(input dcc_pins_t p);
    if (p.cs_n)
      p = {1'b1, ~pins[22:20], p.cke, ~pins[18:0]};
    pins = p;
    repeat (4) @(negedge ref_clk);
    mem_clk = 1'b1;
    repeat (4) @(negedge ref_clk);
    mem_clk = 1'b0;
  endtask
  // Level change with no clock edge
  task hold(input dcc_pins_t p);
    pins = p;
  endtask
endmodule

// ==== tb/dcc_decoder_test.sv ====
`timescale 1ns/100ps
module dcc_decoder_test;
  import dcc_pkg::*;
  localparam logic [3:0] OP_MRS = 4'h0, OP_REF = 4'h1, OP_PRE = 4'h2, OP_ACT = 4'h3;
  localparam logic [3:0] OP_WR = 4'h4, OP_RD = 4'h5, OP_ZQ = 4'h6, OP_NOP = 4'h7;
  localparam logic [3:0] OP_DES = 4'h8;
  // Idle edges granted after a calibration; stands in for the calibration window
  localparam int CAL_WAIT_EDGES = 4;
  logic ref_clk, rst, reset_n, mem_clk;
  dcc_pins_t pins;
  dcc_cmd_t cmd_q;
  dcc_pstate_t pstate_q;
  logic cmd_stb_q, idle_q, burst_active_q, burst_write_q, burst_chop_q;
  logic burst_autoclose_q, mr_write_stb_q;
  logic [2:0] cmd_bank_q;
  logic [1:0] mr_sel_q;
  logic [7:0] bank_open_q;
  logic [15:0] cmd_addr_q, mr_data_q, mr0_q;
  int fails, check_count;
  dcc_decoder dut (.*);
  dcc_ctrl_model m (.ref_clk, .mem_clk, .pins);
  always #10 ref_clk = ~ref_clk;
  task op(input logic [3:0] c, input logic k, input logic [2:0] b, input logic [15:0] a);
    m.cyc({c, k, b, a});
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    print_verdict;
  end
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    reset_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    repeat (4) op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    chk("cmd", DCC_IDLE_CYCLE, cmd_q);
    chk("idle", 1'b1, idle_q);
    $display("test wake done");
    op(OP_MRS, 1'b1, 3'h0, 16'h0001);
    chk("mr0", 16'h0001, mr0_q);
    op(OP_MRS, 1'b1, 3'h2, 16'h0005);
    chk("mr_sel", 2'h2, mr_sel_q);
    chk("mr_data", 16'h0005, mr_data_q);
    op(OP_MRS, 1'b1, 3'h4, 16'h0002);
    chk("mr0", 16'h0001, mr0_q);
    $display("test mode done");
    op(OP_ACT, 1'b1, 3'h3, 16'h0010);
    chk("cmd", DCC_ROW_OPEN, cmd_q);
    chk("banks", 8'h08, bank_open_q);
    op(OP_DES, 1'b1, 3'h0, 16'h0000);
    chk("cmd", DCC_DESELECT, cmd_q);
    chk("idle", 1'b0, idle_q);
    op(OP_RD, 1'b1, 3'h3, 16'h0400);
    chk("chop", 1'b1, burst_chop_q);
    chk("autoclose", 1'b1, burst_autoclose_q);
    op(OP_WR, 1'b1, 3'h3, 16'h1000);
    chk("cmd", DCC_WRITE, cmd_q);
    chk("write", 1'b0, burst_write_q);
    repeat (2) op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    chk("burst", 1'b0, burst_active_q);
    chk("banks", 8'h00, bank_open_q);
    op(OP_ACT, 1'b1, 3'h1, 16'h0000);
    op(OP_RD, 1'b1, 3'h1, 16'h1000);
    chk("chop", 1'b0, burst_chop_q);
    chk("autoclose", 1'b0, burst_autoclose_q);
    repeat (4) op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    op(OP_PRE, 1'b1, 3'h0, 16'h0400);
    chk("cmd", DCC_ALL_BANK_CLOSE, cmd_q);
    chk("banks", 8'h00, bank_open_q);
    $display("test access done");
    op(OP_ZQ, 1'b1, 3'h0, 16'h0400);
    chk("cmd", DCC_LONG_IMPEDANCE_CAL, cmd_q);
    repeat (CAL_WAIT_EDGES) op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    op(OP_ZQ, 1'b1, 3'h0, 16'h0000);
    chk("cmd", DCC_SHORT_IMPEDANCE_CAL, cmd_q);
    repeat (CAL_WAIT_EDGES) op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    $display("test calibration done");
    repeat (2) op(OP_NOP, 1'b0, 3'h0, 16'h0000);
    chk("pstate", DCC_AWAKE, pstate_q);
    op(OP_NOP, 1'b0, 3'h0, 16'h0000);
    chk("pstate", DCC_PRECHARGE_PD, pstate_q);
    op(OP_ACT, 1'b0, 3'h2, 16'h0000);
    chk("banks", 8'h00, bank_open_q);
    repeat (3) op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    chk("pstate", DCC_AWAKE, pstate_q);
    op(OP_ACT, 1'b1, 3'h5, 16'h0000);
    repeat (3) op(OP_NOP, 1'b0, 3'h0, 16'h0000);
    chk("pstate", DCC_ACTIVE_PD, pstate_q);
    repeat (3) op(OP_DES, 1'b1, 3'h0, 16'h0000);
    chk("pstate", DCC_AWAKE, pstate_q);
    op(OP_PRE, 1'b1, 3'h5, 16'h0000);
    chk("cmd", DCC_PRECHARGE, cmd_q);
    chk("banks", 8'h00, bank_open_q);
    $display("test power-down done");
    op(OP_NOP, 1'b1, 3'h0, 16'h0000);
    repeat (2) op(OP_NOP, 1'b0, 3'h0, 16'h0000);
    op(OP_REF, 1'b0, 3'h0, 16'h0000);
    chk("pstate", DCC_SELF_REFRESH, pstate_q);
    m.hold({OP_NOP, 1'b1, 3'h0, 16'h0000});
    repeat (8) @(negedge ref_clk);
    chk("pstate", DCC_AWAKE, pstate_q);
    chk("cmd", DCC_SELF_REFRESH_EXIT, cmd_q);
    $display("test self refresh done");
    print_verdict;
  end
endmodule
